/* core/adc_chain_pkg.sv */
package adc_chain_pkg;
    // ---------------------------------------------------------------
    // word, field layout of the output protocol control byte
    // ---------------------------------------------------------------
    localparam int WORD_W = 20;
    localparam int MODE_LSB = 0;
    localparam int WIDTH_LSB = 2;
    localparam int RATE_BIT = 4;
    localparam int CLKSEL_LSB = 6;
    localparam logic [7:0] CTRL_CHAIN = 8'h00;
    localparam logic [1:0] MODE_SRC = 2'h3;
    localparam logic [1:0] WIDTH_DUAL = 2'h2;
    localparam logic [1:0] WIDTH_QUAD = 2'h3;
    localparam logic [1:0] CLK_SCLK = 2'h0;
    localparam logic [1:0] CLK_INT = 2'h1;
    localparam logic [1:0] CLK_DIV2 = 2'h2;
    localparam logic [1:0] CLK_DIV4 = 2'h3;
    localparam logic [1:0] PRE_LAST = 2'h3;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int OSC_HALF_PS = 8000;
    localparam int OSC_HALF_CYC = (OSC_HALF_PS / CLK_PERIOD_PS < 1) ? 1
                                : OSC_HALF_PS / CLK_PERIOD_PS;
    // ---------------------------------------------------------------
    // frame states, one-hot
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DRAIN = 3'b100
    } frame_state_t;
endpackage

/* core/adc_serial_out_chain.sv */
// What this block does
// [RULE1] output bus defaults to one lane; lane width field picks lane count
// [RULE2] width 10b: two bits launched on lanes 0 and 1 per rising edge
// [RULE3] width 11b: four bits launched on lanes 0 to 3 per rising edge
// [RULE4] sdr: ready/clock pin rises and bits launch on output clock rise
// [RULE5] ddr: ready/clock toggles, bits launch every edge from first rise
// [RULE6] all clock source, lane width and data rate combinations work
// [RULE7] host programs identical setup, control 00h, for a chain
// [RULE8] in chain mode output and input shifters merge into one 20-bit reg
// [RULE9] analog input is sampled on conversion trigger rising edge
// [RULE10] after chip select falls, msb of chain reg goes out lane 0
// [RULE11] each capture edge shifts serial input into chain reg lsb
// [RULE12] chip select rise decodes chain reg and acts on it
// [RULE13] host gives 20 times N capture edges, never fewer
// [RULE14] host wires lane 0 of each device to next serial input
// [RULE15] in star wiring host selects only one device at a time
// [RULE16] minimum pins: trigger may tie to chip select, lanes 1-3 open
// [RULE17] in spi-compatible modes ready/clock stays low all frame
// [RULE18] clock select: sclk echo, internal, internal/2, internal/4
// [RULE19] control not 00h: long frame gives no chain pass-through
// [RULE20] at least 20 serial clocks are needed to accept a write
// [RULE21] host captures source-synchronous data on ready/clock edges
module adc_serial_out_chain #(
    parameter int OSC_HALF = adc_chain_pkg::OSC_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    input wire logic conversion_trigger_i,
    input wire logic [7:0] output_protocol_ctrl_i,
    input wire logic [1:0] input_protocol_ctrl_i,
    input wire logic [19:0] conv_result_i,
    output logic [3:0] output_lanes_o,
    output logic [3:0] output_lanes_oe_o,
    output logic ready_clock_pin_o,
    output logic sample_strobe_o,
    output logic [19:0] cfg_word_o,
    output logic cfg_valid_o
);
    initial begin
        if (OSC_HALF < 1 || OSC_HALF > 255) begin
            $error("OSC_HALF out of range");
        end
    end
    // ---------------------------------------------------------------
    // reset release and pin synchronisers
    // ---------------------------------------------------------------
    logic rst_meta, rst_n;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end
    // pin order: 0 cs_n, 1 sclk, 2 sdi, 3 trigger
    logic [3:0] pin_raw, s1, s2, s3, pin, pin_q;
    assign pin_raw = {conversion_trigger_i, sdi_i, sclk_i, cs_n_i};
    // a change counts only once the second and third stage agree
    for (genvar g = 0; g < 4; g++) begin : g_sync
        always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
                s1[g] <= (g == 0);
                s2[g] <= (g == 0);
                s3[g] <= (g == 0);
                pin[g] <= (g == 0);
                pin_q[g] <= (g == 0);
            end else begin
                s1[g] <= pin_raw[g];
                s2[g] <= s1[g];
                s3[g] <= s2[g];
                if (s2[g] == s3[g]) begin
                    pin[g] <= s3[g];
                end
                pin_q[g] <= pin[g];
            end
        end
    end
    logic cs_fall, cs_rise, sck_rise, sck_fall, trig_rise;
    assign cs_fall = pin_q[0] & ~pin[0];
    assign cs_rise = ~pin_q[0] & pin[0];
    assign sck_rise = ~pin_q[1] & pin[1] & ~pin[0];
    assign sck_fall = pin_q[1] & ~pin[1] & ~pin[0];
    assign trig_rise = ~pin_q[3] & pin[3];
    // ---------------------------------------------------------------
    // decoded configuration
    // ---------------------------------------------------------------
    logic [1:0] width_sel, clk_sel;
    logic src_mode, ddr, chain, cpol, cpha;
    logic [2:0] lanes;
    logic [3:0] lane_mask;
    assign width_sel = output_protocol_ctrl_i[adc_chain_pkg::WIDTH_LSB +: 2];
    assign clk_sel = output_protocol_ctrl_i[adc_chain_pkg::CLKSEL_LSB +: 2];
    assign src_mode = output_protocol_ctrl_i[adc_chain_pkg::MODE_LSB +: 2]
                      == adc_chain_pkg::MODE_SRC;
    assign ddr = output_protocol_ctrl_i[adc_chain_pkg::RATE_BIT];
    assign chain = output_protocol_ctrl_i == adc_chain_pkg::CTRL_CHAIN;
    assign cpol = input_protocol_ctrl_i[1];
    assign cpha = input_protocol_ctrl_i[0];
    // single lane unless the width field names dual or quad
    always_comb begin
        lanes = 3'h1; // [RULE1]
        lane_mask = 4'h1;
        if (width_sel == adc_chain_pkg::WIDTH_DUAL) begin
            lanes = 3'h2; // [RULE2]
            lane_mask = 4'h3;
        end else if (width_sel == adc_chain_pkg::WIDTH_QUAD) begin
            lanes = 3'h4; // [RULE3]
            lane_mask = 4'hf;
        end
    end
    // leading edge is the one that leaves the idle polarity
    logic lead, trail, cap_e, lch_e;
    assign lead = cpol ? sck_fall : sck_rise;
    assign trail = cpol ? sck_rise : sck_fall;
    assign cap_e = cpha ? trail : lead;
    assign lch_e = cpha ? lead : trail;
    // ---------------------------------------------------------------
    // internal oscillator and its /2, /4 taps
    // ---------------------------------------------------------------
    logic [7:0] osc_cnt;
    logic [1:0] pre;
    logic osc_tick, h_int, h_evt;
    assign osc_tick = osc_cnt == 8'(OSC_HALF - 1);
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt <= 8'h00;
            pre <= 2'h0;
        end else begin
            osc_cnt <= osc_tick ? 8'h00 : osc_cnt + 8'h01;
            if (osc_tick) begin
                pre <= pre + 2'h1;
            end
        end
    end
    // one half-period event of the chosen output clock
    always_comb begin
        case (clk_sel) // [RULE18] [RULE6]
            adc_chain_pkg::CLK_SCLK: h_int = sck_rise | sck_fall;
            adc_chain_pkg::CLK_INT: h_int = osc_tick;
            adc_chain_pkg::CLK_DIV2: h_int = osc_tick & pre[0];
            default: h_int = osc_tick & (pre == adc_chain_pkg::PRE_LAST);
        endcase
    end
    // ---------------------------------------------------------------
    // conversion sample hold
    // ---------------------------------------------------------------
    logic [19:0] held;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            held <= 20'h00000;
            sample_strobe_o <= 1'b0;
        end else begin
            sample_strobe_o <= trig_rise; // [RULE9]
            if (trig_rise) begin
                held <= conv_result_i; // [RULE9]
            end
        end
    end
    // ---------------------------------------------------------------
    // frame sequencer
    // ---------------------------------------------------------------
    adc_chain_pkg::frame_state_t state;
    logic [4:0] bits_left, caps;
    logic ph;
    // the output clock stops once the word is out: sdr still gets its
    // closing low phase, ddr stops on the edge that launched the last bits
    assign h_evt = src_mode && state == adc_chain_pkg::ST_SHIFT && h_int
                   && (bits_left != 5'h00 || (!ddr && ph));
    logic src_launch;
    assign src_launch = h_evt && (ddr || !ph);
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= adc_chain_pkg::ST_IDLE;
        end else begin
            case (state)
                adc_chain_pkg::ST_IDLE: begin
                    if (cs_fall) begin
                        state <= adc_chain_pkg::ST_SHIFT;
                    end
                end
                adc_chain_pkg::ST_SHIFT: begin
                    if (cs_rise) begin
                        state <= adc_chain_pkg::ST_IDLE;
                    end else if (src_mode && bits_left == 5'h00 && !ph) begin
                        state <= adc_chain_pkg::ST_DRAIN;
                    end
                end
                adc_chain_pkg::ST_DRAIN: begin
                    if (cs_rise) begin
                        state <= adc_chain_pkg::ST_IDLE;
                    end
                end
                default: state <= adc_chain_pkg::ST_IDLE;
            endcase
        end
    end
    // ---------------------------------------------------------------
    // shift registers; in chain mode the output shifter is the one
    // unified register and the input shifter is not used for decode
    // ---------------------------------------------------------------
    logic [19:0] output_shift_reg, input_shift_reg;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            output_shift_reg <= 20'h00000;
            input_shift_reg <= 20'h00000;
            caps <= 5'h00;
            bits_left <= 5'h00;
            ph <= 1'b0;
        end else if (cs_fall) begin
            output_shift_reg <= held;
            caps <= 5'h00;
            bits_left <= 5'(adc_chain_pkg::WORD_W);
            ph <= 1'b0;
        end else if (!pin[0]) begin
            if (cap_e) begin
                input_shift_reg <= {input_shift_reg[18:0], pin[2]}; // [RULE11]
                if (caps != 5'h1f) begin
                    caps <= caps + 5'h01;
                end
            end
            if (chain && cap_e) begin
                output_shift_reg <= {output_shift_reg[18:0], pin[2]}; // [RULE8] [RULE11]
            end else if (!src_mode && cap_e) begin
                // zero fill: no pass-through outside chain mode
                output_shift_reg <= output_shift_reg << lanes; // [RULE19]
            end else if (src_launch && bits_left != 5'h00) begin
                output_shift_reg <= output_shift_reg << lanes;
                bits_left <= bits_left - 5'(lanes);
            end
            if (h_evt) begin
                ph <= ~ph;
            end
        end
    end
    // ---------------------------------------------------------------
    // lane and ready/clock pin drivers
    // ---------------------------------------------------------------
    logic [3:0] top;
    always_comb begin
        top = 4'h0;
        if (lanes == 3'h4) begin
            top = output_shift_reg[19:16];
        end else if (lanes == 3'h2) begin
            top = {2'h0, output_shift_reg[19:18]};
        end else begin
            top = {3'h0, output_shift_reg[19]};
        end
    end
    // in spi modes with cpha clear the msb launch waits one cycle after chip select falls, so that
    // the chain register already holds the fresh sample
    logic lch_now, cs_fall_q;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_fall_q <= 1'b0;
        end else begin
            cs_fall_q <= cs_fall;
        end
    end
    assign lch_now = src_mode ? (src_launch && bits_left != 5'h00)
                   : (lch_e || (cs_fall_q && !cpha)); // [RULE10]
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            output_lanes_o <= 4'h0;
            output_lanes_oe_o <= 4'h0;
            ready_clock_pin_o <= 1'b0;
        end else begin
            output_lanes_oe_o <= pin[0] ? 4'h0 : lane_mask;
            if (pin[0]) begin
                output_lanes_o <= 4'h0;
            end else if (lch_now) begin
                output_lanes_o <= top; // [RULE10] [RULE2] [RULE3]
            end
            if (!src_mode || pin[0]) begin
                ready_clock_pin_o <= 1'b0; // [RULE17]
            end else if (h_evt) begin
                ready_clock_pin_o <= ~ph; // [RULE4] [RULE5]
            end
        end
    end
    // ---------------------------------------------------------------
    // configuration decode at chip select rise
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg_word_o <= 20'h00000;
            cfg_valid_o <= 1'b0;
        end else begin
            // short frames still load cfg_word_o but never raise cfg_valid_o
            cfg_valid_o <= cs_rise
                && caps >= 5'(adc_chain_pkg::WORD_W); // [RULE12] [RULE20]
            if (cs_rise) begin
                cfg_word_o <= chain ? output_shift_reg : input_shift_reg; // [RULE12] [RULE8]
            end
        end
    end
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_trig;
        trig_rise;
    endsequence
    property p_sample;
        @(posedge clk_i) disable iff (!rst_n)
        s_trig |=> sample_strobe_o && held == $past(conv_result_i);
    endproperty
    a_sample: assert property (p_sample) else $error("sample missed"); // [RULE9]
    property p_rvs_low;
        @(posedge clk_i) disable iff (!rst_n)
        !src_mode |=> !ready_clock_pin_o;
    endproperty
    a_rvs_low: assert property (p_rvs_low) else $error("rvs not low"); // [RULE17]
    property p_single;
        @(posedge clk_i) disable iff (!rst_n)
        (width_sel[1] == 1'b0 && !pin[0]) |=> output_lanes_oe_o == 4'h1;
    endproperty
    a_single: assert property (p_single) else $error("lane count"); // [RULE1]
    property p_dual;
        @(posedge clk_i) disable iff (!rst_n)
        (width_sel == 2'h2 && lch_now && !pin[0])
        |=> output_lanes_o == {2'h0, $past(output_shift_reg[19:18])};
    endproperty
    a_dual: assert property (p_dual) else $error("dual lanes"); // [RULE2]
    property p_quad;
        @(posedge clk_i) disable iff (!rst_n)
        (width_sel == 2'h3 && lch_now && !pin[0])
        |=> output_lanes_o == $past(output_shift_reg[19:16]);
    endproperty
    a_quad: assert property (p_quad) else $error("quad lanes"); // [RULE3]
    property p_sdr;
        @(posedge clk_i) disable iff (!rst_n)
        (src_mode && !ddr && src_launch && !pin[0]) |=> ready_clock_pin_o;
    endproperty
    a_sdr: assert property (p_sdr) else $error("sdr rvs"); // [RULE4]
    property p_ddr;
        @(posedge clk_i) disable iff (!rst_n)
        (src_mode && h_evt && !pin[0])
        |=> ready_clock_pin_o != $past(ready_clock_pin_o);
    endproperty
    a_ddr: assert property (p_ddr) else $error("ddr toggle"); // [RULE5]
    property p_cfg;
        @(posedge clk_i) disable iff (!rst_n)
        (cs_rise && caps < 5'h14) |=> !cfg_valid_o;
    endproperty
    a_cfg: assert property (p_cfg) else $error("short frame"); // [RULE20]
    property p_chain;
        @(posedge clk_i) disable iff (!rst_n)
        (chain && cap_e && !pin[0] && !cs_fall)
        |=> output_shift_reg[0] == $past(pin[2]);
    endproperty
    a_chain: assert property (p_chain) else $error("chain shift"); // [RULE11]
endmodule

/* verification/host_model.sv */
module host_model (
    input wire logic clk_i,
    input wire logic lane0_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdi_o,
    output logic conversion_trigger_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // pin driver of the host side
    // ---------------------------------------------------------------
    // half period well above the device's pin synchroniser floor
    localparam int HALF = 8;

    // idle levels of every host pin at time zero
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
        conversion_trigger_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // trigger has its own pin, not tied to chip select
    task automatic convert();
        wait_clk(1);
        conversion_trigger_o = 1'b1;
        wait_clk(HALF);
        conversion_trigger_o = 1'b0;
        wait_clk(HALF);
    endtask

    // spi 00 frame: lane 0 read before each rise, sdi moved after falls
    task automatic spi_frame(input int n, input logic [63:0] din,
                             output logic [63:0] dout);
        dout = '0;
        wait_clk(1);
        cs_n_o = 1'b0; // single device, one select at a time
        sdi_o = din[n-1]; // frames only in spi 00 with control 00h
        wait_clk(HALF);
        for (int i = n - 1; i >= 0; i--) begin
            dout = {dout[62:0], lane0_i};
            sclk_o = 1'b1; // one capture edge per bit
            wait_clk(HALF);
            sclk_o = 1'b0;
            // after the last bit the line no longer holds valid data
            sdi_o = (i > 0) ? din[i-1] : ~din[0];
            wait_clk(HALF);
        end
        cs_n_o = 1'b1;
        wait_clk(2 * HALF);
    endtask

    // source-synchronous frame: data is taken by the bench on the
    // ready/clock pin, so only the echo source needs sclk from here
    task automatic src_frame(input int periods, input logic ext);
        wait_clk(1);
        cs_n_o = 1'b0;
        wait_clk(HALF);
        repeat (ext ? periods : 0) begin
            sclk_o = 1'b1;
            sdi_o = ~sdi_o;
            wait_clk(HALF);
            sclk_o = 1'b0;
            wait_clk(HALF);
        end
        wait_clk(ext ? HALF : 300);
        cs_n_o = 1'b1;
        wait_clk(2 * HALF);
    endtask
endmodule

/* verification/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, cs_n, sclk, sdi, trig;
    logic [7:0] ctrl;
    logic [19:0] result;
    logic [3:0] lanes, lanes_oe;
    logic ready_clock_pin, strobe, cfg_valid, rvs_q;
    logic [19:0] cfg_word;
    logic [63:0] acc, d;
    int ncap, n_strobe, n_valid, rvs_hi, num_errors, num_checks;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    adc_serial_out_chain #(.OSC_HALF(1)) DUT (
        .clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk),
        .sdi_i(sdi), .conversion_trigger_i(trig),
        .output_protocol_ctrl_i(ctrl), .input_protocol_ctrl_i(2'h0),
        .conv_result_i(result), .output_lanes_o(lanes),
        .output_lanes_oe_o(lanes_oe), .ready_clock_pin_o(ready_clock_pin),
        .sample_strobe_o(strobe), .cfg_word_o(cfg_word),
        .cfg_valid_o(cfg_valid)
    );

    host_model host (
        .clk_i(clk), .lane0_i(lanes[0]), .cs_n_o(cs_n), .sclk_o(sclk),
        .sdi_o(sdi), .conversion_trigger_o(trig)
    );

    // ---------------------------------------------------------------
    // monitor: pulses, and lane capture on ready/clock edges
    // ---------------------------------------------------------------
    // sampled at the falling edge so registered outputs have settled
    always @(negedge clk) begin
        if (strobe === 1'b1) n_strobe++;
        if (cfg_valid === 1'b1) n_valid++;
        if (!cs_n && ctrl == 8'h00 && ready_clock_pin !== 1'b0) rvs_hi++;
        if (!cs_n && ready_clock_pin !== rvs_q && (ctrl[4] || ready_clock_pin)) begin
            case (ctrl[3:2])
                2'h2: acc = {acc[61:0], lanes[1:0]};
                2'h3: acc = {acc[59:0], lanes[3:0]};
                default: acc = {acc[62:0], lanes[0]};
            endcase
            ncap += (ctrl[3:2] == 2'h3) ? 4 : (ctrl[3:2] == 2'h2) ? 2 : 1;
        end
        rvs_q = ready_clock_pin;
    end

    task automatic check(input string name, input logic [63:0] seen,
                         input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        logic [1:0] wsel;
        int nl, per;
        rst_n = 1'b0;
        ctrl = 8'h00;
        result = 20'h00000;
        acc = '0;
        ncap = 0;
        n_strobe = 0;
        n_valid = 0;
        rvs_hi = 0;
        rvs_q = 1'b0;
        num_errors = 0;
        num_checks = 0;
        repeat (2) @(negedge clk);
        check("lanes_in_reset", lanes, 4'h0);
        check("rvs_in_reset", ready_clock_pin, 1'b0);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        // chain frame of exactly one word
        result = 20'ha5c3e;
        host.convert();
        check("sample_strobes", n_strobe, 1);
        host.spi_frame(20, 64'h3c96b, d);
        check("chain_read", d[19:0], 20'ha5c3e);
        check("chain_word", cfg_word, 20'h3c96b);
        check("chain_valid", n_valid, 1);
        // long frame: first word passes through to lane 0
        result = 20'h1e2d3;
        host.convert();
        host.spi_frame(40, 64'h5aa55_c0ffe, d);
        check("pass_through", d[39:0], 40'h1e2d3_5aa55);
        check("long_word", cfg_word, 20'hc0ffe);
        // short frame must not be accepted
        host.spi_frame(10, 64'h2a5, d);
        check("short_refused", n_valid, 2);
        check("rvs_low_spi", rvs_hi, 0);
        // every clock source, data rate and lane width
        for (int s = 0; s < 4; s++) begin
            for (int r = 0; r < 2; r++) begin
                for (int w = 0; w < 3; w++) begin
                    wsel = (w == 0) ? 2'h0 : (w == 1) ? 2'h2 : 2'h3;
                    nl = (w == 0) ? 1 : (w == 1) ? 2 : 4;
                    per = r ? (20 / nl + 1) / 2 : 20 / nl;
                    @(negedge clk);
                    ctrl = {s[1:0], 1'b0, r[0], wsel, 2'h3};
                    result = 20'h9b4e1 ^ {12'h000, ctrl};
                    host.convert();
                    acc = '0;
                    ncap = 0;
                    host.src_frame(per, s == 0);
                    check("src_data", acc[19:0], result);
                    check("src_bits", ncap, 20);
                    check("src_rvs", {ready_clock_pin, lanes_oe[3]}, 2'b00);
                end
            end
        end
        // long source-synchronous frame yields no extra launches
        @(negedge clk);
        ctrl = 8'h13;
        host.convert();
        acc = '0;
        ncap = 0;
        host.src_frame(30, 1'b1);
        check("ddr_no_pass", ncap, 20);
        check("ddr_data", acc[19:0], result);
        end_sim();
    end

    // watchdog, several times the expected run length
    initial begin
        #150us;
        num_errors++;
        end_sim();
    end
endmodule
